// *** src/adsq_top.sv ***
// Converter sequencer with single, continuous, accumulate and sample buffer modes
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module adsq_top #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Converter core and input multiplexer
	output logic conv_sample,
	output logic conv_latch,
	output logic [2:0] conv_chan,
	output logic conv_range,
	input wire logic [9:0] conv_data,
	// Timer repeat events
	input wire logic [adsq_pkg::MAX_TIMER:0] timer_evt,
	// Sample memory write port
	output logic mem_wr,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [15:0] mem_wdata,
	// Interrupt lines
	output logic conv_irq,
	output logic buf_irq
);
	import adsq_pkg::*;

	function automatic logic [5:0] conv_len(input logic [1:0] sel);
		logic [5:0] ivl;
		ivl = {3'h0, sel, 1'b0} + 6'h02;
		return 6'(ivl * SAMPLE_MULT) + CONV_TAIL_CLKS;
	endfunction

	// Lowest set bit wins, which fixes the storage order of a trigger group
	function automatic logic [2:0] first_set(input logic [7:0] m);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (m[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	logic [31:0] ctrl_ff;
	logic [31:0] bufcfg_ff;
	logic [15:0] bufstart_ff;
	logic [10:0] buflen_ff;
	logic [15:0] clkdiv_ff;
	logic [15:0] div_cnt_ff;
	adsq_state_e state_ff;
	adsq_mode_e mode_ff;
	logic [5:0] tick_cnt_ff;
	logic [4:0] acc_left_ff;
	logic acc_first_ff;
	logic [7:0] pend_ff;
	logic [13:0] result_ff;
	logic [4:0] flags_ff;
	logic buf_act_ff;
	logic [10:0] ptr_ff;
	logic [2:0] chan_ff;
	logic range_ff;
	logic [31:0] rdata_ff;
	logic mem_wr_ff;
	logic [ADDR_W-1:0] mem_addr_ff;
	logic [15:0] mem_wdata_ff;

	logic cmd_wr;
	logic start_cmd;
	logic acc_cmd;
	logic stop_cmd;
	logic buf_start;
	logic buf_stop;
	logic tick;
	logic conv_end;
	logic trig;
	logic [7:0] src_map;
	logic [2:0] tsel;
	logic buf_wrap;
	logic buf_stall;
	logic [10:0] nxt_ptr;
	logic [7:0] nxt_pend;
	logic [4:0] flag_set;
	logic [4:0] flag_clr;
	logic [4:0] nxt_flags;

	assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
	assign start_cmd = cmd_wr && reg_wdata[CMD_START] && ctrl_ff[CTRL_EN] && !buf_act_ff;
	assign acc_cmd = cmd_wr && reg_wdata[CMD_ACC] && ctrl_ff[CTRL_EN] && !buf_act_ff;
	assign stop_cmd = cmd_wr && reg_wdata[CMD_STOP];
	assign buf_start = cmd_wr && reg_wdata[CMD_BUF_START];
	assign buf_stop = cmd_wr && reg_wdata[CMD_BUF_STOP];
	assign src_map = bufcfg_ff[BCFG_SRC +: 8];
	assign tsel = bufcfg_ff[BCFG_TIMER +: 3];
	assign buf_wrap = bufcfg_ff[BCFG_WRAP];
	// Only timers 0..4 exist; a larger selection never triggers
	assign trig = buf_act_ff && (state_ff == ST_IDLE) && (src_map != 8'h00)
		&& (tsel <= 3'(MAX_TIMER)) && timer_evt[tsel];
	assign tick = (div_cnt_ff == 16'h0000);
	assign conv_end = (state_ff == ST_CONV) && tick && (tick_cnt_ff == 6'h01);
	assign nxt_pend = pend_ff & ~(8'h01 << chan_ff);
	// A zero-length buffer can never take a sample, wrap or not
	assign buf_stall = (ptr_ff >= buflen_ff) && (!buf_wrap || buflen_ff == 11'h000);
	assign nxt_ptr = ptr_ff + 11'h001;

	// Converter clock divider
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt_ff <= 16'h0000;
		end else if (tick || state_ff == ST_IDLE) begin
			div_cnt_ff <= clkdiv_ff;
		end else begin
			div_cnt_ff <= div_cnt_ff - 16'h0001;
		end
	end

	// Configuration registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_ff <= CTRL_RST;
			bufcfg_ff <= BUFCFG_RST;
			bufstart_ff <= 16'h0000;
			buflen_ff <= 11'h000;
			clkdiv_ff <= CLKDIV_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: ctrl_ff <= {23'h00_0000, reg_wdata[8:0]};
				REG_BUFCFG: bufcfg_ff <= {16'h0000, reg_wdata[15:0]};
				REG_BUFSTART: bufstart_ff <= reg_wdata[15:0];
				REG_BUFLEN: buflen_ff <= reg_wdata[10:0];
				REG_CLKDIV: clkdiv_ff <= reg_wdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// Conversion sequencer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			mode_ff <= MD_SINGLE;
			tick_cnt_ff <= 6'h00;
			acc_left_ff <= 5'h00;
			pend_ff <= 8'h00;
			chan_ff <= 3'h0;
			range_ff <= 1'b0;
		end else if ((stop_cmd && mode_ff != MD_BUF) || (buf_stop && mode_ff == MD_BUF)) begin
			state_ff <= ST_IDLE;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					tick_cnt_ff <= conv_len(ctrl_ff[CTRL_IVL +: 2]);
					if (acc_cmd) begin
						state_ff <= ST_CONV;
						mode_ff <= MD_ACCUM;
						acc_left_ff <= 5'h02 << reg_wdata[CMD_ACC_SEL +: 2];
						chan_ff <= ctrl_ff[CTRL_CHAN +: 3];
						range_ff <= ctrl_ff[CTRL_RANGE];
					end else if (start_cmd) begin
						state_ff <= ST_CONV;
						mode_ff <= ctrl_ff[CTRL_CONT] ? MD_CONT : MD_SINGLE;
						chan_ff <= ctrl_ff[CTRL_CHAN +: 3];
						range_ff <= ctrl_ff[CTRL_RANGE];
					end else if (trig) begin
						state_ff <= ST_CONV;
						mode_ff <= MD_BUF;
						pend_ff <= src_map;
						chan_ff <= first_set(src_map);
						range_ff <= bufcfg_ff[BCFG_RANGE];
					end
				end
				ST_CONV: begin
					if (tick && tick_cnt_ff == 6'h01) begin
						tick_cnt_ff <= conv_len(ctrl_ff[CTRL_IVL +: 2]);
						case (mode_ff)
							MD_SINGLE: state_ff <= ST_IDLE;
							MD_CONT: state_ff <= ST_CONV;
							MD_ACCUM: begin
								acc_left_ff <= acc_left_ff - 5'h01;
								if (acc_left_ff == 5'h01) begin
									state_ff <= ST_IDLE;
								end
							end
							MD_BUF: begin
								pend_ff <= nxt_pend;
								chan_ff <= first_set(nxt_pend);
								if (nxt_pend == 8'h00) begin
									state_ff <= ST_IDLE;
								end
							end
							default: state_ff <= ST_IDLE;
						endcase
					end else if (tick) begin
						tick_cnt_ff <= tick_cnt_ff - 6'h01;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Result register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			result_ff <= 14'h0000;
			acc_first_ff <= 1'b0;
		end else begin
			if (state_ff == ST_IDLE) begin
				acc_first_ff <= 1'b1;
			end else if (conv_end) begin
				acc_first_ff <= 1'b0;
			end
			if (conv_end && mode_ff != MD_BUF) begin
				if (mode_ff == MD_ACCUM && !acc_first_ff) begin
					result_ff <= result_ff + {4'h0, conv_data};
				end else begin
					result_ff <= {4'h0, conv_data};
				end
			end
		end
	end

	// Buffer run state and DMA write
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			buf_act_ff <= 1'b0;
			ptr_ff <= 11'h000;
			mem_wr_ff <= 1'b0;
			mem_addr_ff <= '0;
			mem_wdata_ff <= 16'h0000;
		end else begin
			mem_wr_ff <= 1'b0;
			if (buf_stop) begin
				buf_act_ff <= 1'b0;
			end else if (buf_start) begin
				buf_act_ff <= 1'b1;
			end
			if (buf_start || (reg_wr && reg_addr == REG_BUFPTR)) begin
				ptr_ff <= 11'h000;
			end else if (conv_end && mode_ff == MD_BUF && !buf_stall) begin
				mem_wr_ff <= 1'b1;
				mem_addr_ff <= ADDR_W'(bufstart_ff + {4'h0, ptr_ff, 1'b0});
				mem_wdata_ff <= {6'h00, conv_data};
				if (nxt_ptr == buflen_ff && buf_wrap) begin
					ptr_ff <= 11'h000;
				end else begin
					ptr_ff <= nxt_ptr;
				end
			end
		end
	end

	// Sticky flags; a hardware set beats a same-cycle clear
	always_comb begin
		flag_set = 5'h00;
		flag_set[ST_DONE] = conv_end && (mode_ff == MD_SINGLE || mode_ff == MD_CONT
			|| (mode_ff == MD_ACCUM && acc_left_ff == 5'h01));
		if (conv_end && mode_ff == MD_BUF) begin
			flag_set[ST_OVF] = buf_stall;
			flag_set[ST_HALF] = !buf_stall && nxt_ptr == (buflen_ff >> 1);
			flag_set[ST_FULL] = !buf_stall && nxt_ptr == buflen_ff;
			flag_set[ST_WRAP] = !buf_stall && nxt_ptr == buflen_ff && buf_wrap;
		end
		flag_clr = (reg_wr && reg_addr == REG_STATUS) ? reg_wdata[4:0] : 5'h00;
		nxt_flags = (flags_ff & ~flag_clr) | flag_set;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_ff <= 5'h00;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// Register read, data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: rdata_ff <= ctrl_ff;
				REG_STATUS: rdata_ff <= {22'h00_0000, buf_act_ff, state_ff == ST_CONV,
					3'h0, flags_ff};
				REG_RESULT: rdata_ff <= {18'h0_0000, result_ff};
				REG_BUFCFG: rdata_ff <= bufcfg_ff;
				REG_BUFSTART: rdata_ff <= {16'h0000, bufstart_ff};
				REG_BUFLEN: rdata_ff <= {21'h00_0000, buflen_ff};
				REG_BUFPTR: rdata_ff <= {21'h00_0000, ptr_ff};
				REG_CLKDIV: rdata_ff <= {16'h0000, clkdiv_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_ff;
	assign conv_sample = (state_ff == ST_CONV) && (tick_cnt_ff > CONV_TAIL_CLKS);
	assign conv_latch = conv_end;
	assign conv_chan = chan_ff;
	assign conv_range = range_ff;
	assign mem_wr = mem_wr_ff;
	assign mem_addr = mem_addr_ff;
	assign mem_wdata = mem_wdata_ff;
	assign conv_irq = flags_ff[ST_DONE] && ctrl_ff[CTRL_INT_EN];
	assign buf_irq = flags_ff[ST_OVF]
		|| (bufcfg_ff[BCFG_IRQ +: 2] == IRQ_HALF && flags_ff[ST_HALF])
		|| (bufcfg_ff[BCFG_IRQ +: 2] == IRQ_FULL && flags_ff[ST_FULL])
		|| (bufcfg_ff[BCFG_IRQ +: 2] == IRQ_WRAP && flags_ff[ST_WRAP]);

	sequence buf_launch_s;
		trig && !buf_stop;
	endsequence

	sequence next_group_s;
		conv_end && mode_ff == MD_BUF && nxt_pend != 8'h00 && !buf_stop;
	endsequence

	single_stop_a: assert property (@(posedge clk) disable iff (!rstn)
		conv_end && mode_ff == MD_SINGLE |=> state_ff == ST_IDLE [*2])
		else $error("single-shot did not stay idle");
	start_enable_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == ST_IDLE ##1 state_ff == ST_CONV && mode_ff != MD_BUF
		|-> $past(ctrl_ff[CTRL_EN]))
		else $error("conversion began while disabled");
	cont_rerun_a: assert property (@(posedge clk) disable iff (!rstn)
		conv_end && mode_ff == MD_CONT && !stop_cmd |=> state_ff == ST_CONV)
		else $error("continuous mode paused");
	conv_len_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == ST_IDLE ##1 state_ff == ST_CONV
		|-> tick_cnt_ff == 6'(6 * ($past(ctrl_ff[CTRL_IVL +: 2]) + 1)) + 6'h0D)
		else $error("conversion length wrong");
	result_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!conv_end |=> $stable(result_ff))
		else $error("result changed without a conversion");
	accum_sum_a: assert property (@(posedge clk) disable iff (!rstn)
		conv_end && mode_ff == MD_ACCUM && !acc_first_ff
		|=> result_ff == $past(result_ff) + {4'h0, $past(conv_data)})
		else $error("accumulated sum wrong");
	accum_done_a: assert property (@(posedge clk) disable iff (!rstn)
		conv_end && mode_ff == MD_ACCUM && acc_left_ff != 5'h01 && !flags_ff[ST_DONE]
		|=> !flags_ff[ST_DONE])
		else $error("done raised before accumulation end");
	stop_a: assert property (@(posedge clk) disable iff (!rstn)
		stop_cmd && mode_ff != MD_BUF |=> state_ff == ST_IDLE)
		else $error("stop command ignored");
	order_a: assert property (@(posedge clk) disable iff (!rstn)
		buf_launch_s or next_group_s |=> pend_ff[conv_chan]
		&& (pend_ff & ((8'h01 << conv_chan) - 8'h01)) == 8'h00
		&& conv_range == bufcfg_ff[BCFG_RANGE])
		else $error("group order or range wrong");
	overflow_a: assert property (@(posedge clk) disable iff (!rstn)
		conv_end && mode_ff == MD_BUF && buf_stall && !buf_start
		&& !(reg_wr && reg_addr == REG_BUFPTR) |=> !mem_wr && flags_ff[ST_OVF] && buf_irq)
		else $error("overflow sample not discarded");
	dma_write_a: assert property (@(posedge clk) disable iff (!rstn)
		conv_end && mode_ff == MD_BUF && !buf_stall && !buf_start
		&& !(reg_wr && reg_addr == REG_BUFPTR) |=> mem_wr && mem_wdata == {6'h00, $past(conv_data)})
		else $error("sample not written");
endmodule

// *** src/adsq_pkg.sv ***
// Shared constants for the converter sequencer and sample buffer
package adsq_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RESULT = 8'h0C;
	localparam logic [7:0] REG_BUFCFG = 8'h10;
	localparam logic [7:0] REG_BUFSTART = 8'h14;
	localparam logic [7:0] REG_BUFLEN = 8'h18;
	localparam logic [7:0] REG_BUFPTR = 8'h1C;
	localparam logic [7:0] REG_CLKDIV = 8'h20;
	// Control register fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_CONT = 1;
	localparam int CTRL_RANGE = 2;
	localparam int CTRL_IVL = 3;
	localparam int CTRL_INT_EN = 5;
	localparam int CTRL_CHAN = 6;
	// Command register fields
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_ACC = 2;
	localparam int CMD_ACC_SEL = 3;
	localparam int CMD_BUF_START = 5;
	localparam int CMD_BUF_STOP = 6;
	// Status register fields; bits 0..4 are sticky, write one to clear
	localparam int ST_DONE = 0;
	localparam int ST_HALF = 1;
	localparam int ST_FULL = 2;
	localparam int ST_WRAP = 3;
	localparam int ST_OVF = 4;
	localparam int ST_BUSY = 8;
	localparam int ST_BUF_ACT = 9;
	// Buffer configuration fields
	localparam int BCFG_TIMER = 0;
	localparam int BCFG_RANGE = 3;
	localparam int BCFG_WRAP = 4;
	localparam int BCFG_IRQ = 5;
	localparam int BCFG_SRC = 8;
	// Buffer interrupt selections
	localparam logic [1:0] IRQ_HALF = 2'h0;
	localparam logic [1:0] IRQ_FULL = 2'h1;
	localparam logic [1:0] IRQ_WRAP = 2'h2;
	// Conversion timing in converter clock periods
	localparam logic [5:0] SAMPLE_MULT = 6'h03;
	localparam logic [5:0] CONV_TAIL_CLKS = 6'h0D;
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned CONV_CLK_HZ = 500000;
	localparam logic [15:0] CLKDIV_RST = 16'(CLK_HZ / CONV_CLK_HZ - 1);
	localparam int unsigned MAX_TIMER = 4;
	localparam logic [10:0] BUF_LEN_MAX = 11'h7FF;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] BUFCFG_RST = 32'h0000_0000;
	typedef enum logic {ST_IDLE, ST_CONV} adsq_state_e;
	typedef enum logic [1:0] {MD_SINGLE, MD_CONT, MD_ACCUM, MD_BUF} adsq_mode_e;
endpackage

// *** testbench/adsq_conv_model.sv ***
// Behavioural converter core and input multiplexer facing the sequencer
`timescale 1ns/1ns
module adsq_conv_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Sequencer side
	input wire logic conv_latch,
	input wire logic [2:0] conv_chan,
	input wire logic conv_range,
	output logic [9:0] conv_data
);
	logic [4:0] seq_ff;
	logic [9:0] val;
	// Range, input and a running count, so a stale or swapped sample is visible
	assign val = {1'h0, conv_range, conv_chan, seq_ff};
	// Off the capture cycle the line shows the inverse, never a lucky match
	assign conv_data = conv_latch ? val : ~val;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seq_ff <= 5'h00;
		end else if (conv_latch) begin
			seq_ff <= seq_ff + 5'h01;
		end
	end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the converter sequencer and sample buffer
`timescale 1ns/1ns
module tb;
	import adsq_pkg::*;
	typedef struct {logic [1:0] ivl; logic [2:0] chan; logic rng; int cyc;} adsq_row_s;
	logic clk;
	logic rstn;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic conv_sample;
	logic conv_latch;
	logic [2:0] conv_chan;
	logic conv_range;
	logic [9:0] conv_data;
	logic [MAX_TIMER:0] timer_evt;
	logic mem_wr;
	logic [15:0] mem_addr;
	logic [15:0] mem_wdata;
	logic conv_irq;
	logic buf_irq;
	int mismatches;
	int n_tests;
	int n_lat;
	int n_smp;
	int n0;
	int cyc;
	logic irq_seen;
	logic [31:0] acc_sum;
	logic [31:0] rd;
	logic [9:0] last_val;
	logic [13:0] lat_q[$];
	logic [31:0] wr_q[$];
	adsq_row_s rows[4] = '{'{2'h0, 3'h0, 1'h0, 19}, '{2'h1, 3'h3, 1'h1, 25},
		'{2'h2, 3'h5, 1'h0, 31}, '{2'h3, 3'h7, 1'h1, 37}};
	logic [7:0] rst_addr[7] = '{REG_CTRL, REG_CMD, REG_STATUS, REG_RESULT, REG_BUFCFG,
		REG_CLKDIV, 8'h3C};
	logic [31:0] rst_exp[7] = '{CTRL_RST, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		BUFCFG_RST, 32'(CLKDIV_RST), 32'h0000_0000};
	logic [2:0] ord[3] = '{3'h0, 3'h6, 3'h7};

	adsq_top u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_sample(conv_sample),
		.conv_latch(conv_latch), .conv_chan(conv_chan), .conv_range(conv_range),
		.conv_data(conv_data), .timer_evt(timer_evt), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .conv_irq(conv_irq), .buf_irq(buf_irq));
	adsq_conv_model u_conv (.clk(clk), .rstn(rstn), .conv_latch(conv_latch),
		.conv_chan(conv_chan), .conv_range(conv_range), .conv_data(conv_data));

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		if (conv_latch) begin
			n_lat <= n_lat + 1;
			acc_sum <= acc_sum + 32'(conv_data);
			last_val <= conv_data;
			lat_q.push_back({conv_range, conv_chan, conv_data});
		end
		if (mem_wr)
			wr_q.push_back({mem_addr, mem_wdata});
		if (conv_sample)
			n_smp <= n_smp + 1;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		rd = reg_rdata;
	endtask

	// Counts cycles up to the next capture pulse; the bound keeps a dead converter from hanging
	// c0 is the command edge that a write already spent before the count starts
	task automatic wait_latch(input int c0);
		cyc = c0;
		irq_seen = 1'h0;
		do begin
			@(posedge clk);
			#1;
			cyc++;
			irq_seen |= conv_irq;
		end while (conv_latch !== 1'h1 && cyc < 400);
		chk("latch_seen", 32'(conv_latch), 32'h0000_0001);
	endtask

	task automatic pulse(input int t);
		@(posedge clk);
		timer_evt <= 5'h01 << t;
		@(posedge clk);
		timer_evt <= 5'h00;
	endtask

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		#(8 * 20000);
		mismatches++;
		end_sim();
	end

	initial begin
		rstn = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		timer_evt = 5'h00;
		mismatches = 0;
		n_tests = 0;
		n_lat = 0;
		n_smp = 0;
		acc_sum = 32'h0000_0000;
		repeat (20) @(posedge clk);
		chk("rst_out", 32'({conv_irq, buf_irq, mem_wr, conv_latch}), 32'h0000_0000);
		rstn <= 1'h1;
		foreach (rst_addr[i]) begin
			rdr(rst_addr[i]);
			chk("rst_reg", rd, rst_exp[i]);
		end
		wr(8'h3C, 32'hFFFF_FFFF);
		rdr(8'h3C);
		chk("unmapped", rd, 32'h0000_0000);
		// Fastest converter tick keeps every conversion at its bare tick count
		wr(REG_CLKDIV, 32'h0000_0000);
		foreach (rows[i]) begin
			wr(REG_CTRL, {23'h0, rows[i].chan, 1'h1, rows[i].ivl, rows[i].rng, 2'h1});
			n0 = n_smp;
			wr(REG_CMD, 32'h0000_0001);
			wait_latch(1);
			chk("conv_time", 32'(cyc), 32'(rows[i].cyc));
			@(posedge clk);
			#1;
			chk("chan", 32'(lat_q[$][13:10]), 32'({rows[i].rng, rows[i].chan}));
			chk("done_irq", 32'(conv_irq), 32'h0000_0001);
			rdr(REG_RESULT);
			chk("result", rd, 32'(last_val));
			repeat (50) @(posedge clk);
			chk("single_cnt", 32'(n_lat), 32'(i + 1));
			chk("sample_len", 32'(n_smp - n0), 32'(6 * (rows[i].ivl + 1)));
			wr(REG_STATUS, 32'h0000_001F);
		end
		wr(REG_CMD, 32'h0000_0002);
		wr(REG_CTRL, 32'h0000_0083);
		wr(REG_CMD, 32'h0000_0001);
		wait_latch(1);
		repeat (3) begin
			wait_latch(0);
			chk("cont_gap", 32'(cyc), 32'd19);
		end
		rdr(REG_RESULT);
		chk("cont_result", rd, 32'(last_val));
		rdr(REG_STATUS);
		chk("irq_off", 32'({conv_irq, rd[ST_DONE]}), 32'h0000_0001);
		wr(REG_CMD, 32'h0000_0002);
		repeat (2) @(posedge clk);
		n0 = n_lat;
		repeat (60) @(posedge clk);
		chk("cont_stop", 32'(n_lat), 32'(n0));
		// Continuous is still selected here, accumulation must not inherit it
		wr(REG_CTRL, 32'h0000_0023);
		for (int c = 0; c < 4; c++) begin
			wr(REG_STATUS, 32'h0000_001F);
			acc_sum = 32'h0000_0000;
			n0 = n_lat;
			wr(REG_CMD, 32'(4 + (c << 3)));
			for (int k = 0; k < (2 << c); k++) begin
				wait_latch(int'(k == 0));
				chk("acc_early", 32'({irq_seen, cyc[5:0]}), 32'd19);
			end
			@(posedge clk);
			#1;
			chk("acc_irq", 32'(conv_irq), 32'h0000_0001);
			repeat (50) @(posedge clk);
			chk("acc_cnt", 32'(n_lat - n0), 32'(2 << c));
			rdr(REG_RESULT);
			chk("acc_sum", rd, acc_sum);
		end
		wr(REG_STATUS, 32'h0000_001F);
		wr(REG_CMD, 32'h0000_001C);
		wait_latch(1);
		wait_latch(0);
		wr(REG_CMD, 32'h0000_0002);
		repeat (2) @(posedge clk);
		n0 = n_lat;
		repeat (60) @(posedge clk);
		chk("acc_halt", 32'(n_lat), 32'(n0));
		rdr(REG_STATUS);
		chk("acc_halt_st", 32'({rd[ST_BUSY], rd[ST_DONE]}), 32'h0000_0000);
		wr(REG_CTRL, 32'h0000_0000);
		wr(REG_CMD, 32'h0000_0001);
		repeat (40) @(posedge clk);
		chk("start_off", 32'(n_lat), 32'(n0));
		wr(REG_CTRL, 32'h0000_0001);
		wr(REG_BUFSTART, 32'h0000_1000);
		wr(REG_BUFLEN, 32'h0000_0004);
		wr(REG_BUFCFG, 32'h0000_C12B);
		wr(REG_CMD, 32'h0000_0020);
		lat_q.delete();
		wr_q.delete();
		pulse(2);
		repeat (30) @(posedge clk);
		chk("wrong_timer", 32'(n_lat), 32'(n0));
		pulse(3);
		repeat (70) @(posedge clk);
		chk("grp_words", 32'(wr_q.size()), 32'h0000_0003);
		for (int j = 0; j < 3; j++) begin
			chk("buf_chan", 32'(lat_q[j][13:10]), 32'({1'h1, ord[j]}));
			chk("buf_word", wr_q[j], {16'h1000 + 16'(2 * j), 6'h00, lat_q[j][9:0]});
		end
		rdr(REG_STATUS);
		chk("half_st", {15'h0, buf_irq, rd[15:0] & 16'h031E}, 32'h0000_0202);
		pulse(3);
		repeat (70) @(posedge clk);
		chk("ovf_words", 32'(wr_q.size()), 32'h0000_0004);
		chk("last_addr", 32'(wr_q[3][31:16]), 32'h0000_1006);
		rdr(REG_STATUS);
		chk("ovf_st", {15'h0, buf_irq, rd[15:0] & 16'h031E}, 32'h0001_0216);
		wr(REG_BUFPTR, 32'h0000_0000);
		wr(REG_STATUS, 32'h0000_001F);
		pulse(3);
		repeat (70) @(posedge clk);
		chk("ack_words", 32'(wr_q.size()), 32'h0000_0007);
		chk("ack_addr", 32'(wr_q[4][31:16]), 32'h0000_1000);
		wr(REG_CMD, 32'h0000_0040);
		n0 = n_lat;
		pulse(3);
		repeat (30) @(posedge clk);
		chk("buf_stop", 32'(n_lat), 32'(n0));
		rdr(REG_STATUS);
		chk("buf_act", 32'(rd[ST_BUF_ACT]), 32'h0000_0000);
		wr(REG_BUFLEN, 32'h0000_0002);
		wr(REG_BUFCFG, 32'h0000_0150);
		wr(REG_BUFPTR, 32'h0000_0000);
		wr(REG_STATUS, 32'h0000_001F);
		wr_q.delete();
		wr(REG_CMD, 32'h0000_0020);
		repeat (3) begin
			pulse(0);
			repeat (30) @(posedge clk);
		end
		for (int j = 0; j < 3; j++) begin
			chk("wrap_addr", 32'(wr_q[j][31:16]), 32'h0000_1000 + 32'(2 * (j % 2)));
		end
		rdr(REG_STATUS);
		chk("wrap_st", 32'({buf_irq, rd[ST_OVF], rd[ST_WRAP]}), 32'h0000_0005);
		end_sim();
	end
endmodule
